/* File: src/nsrc_host.sv */
/*
  Host controller for an asynchronous NAND device: software issues
  command, address and data cycles through a small register port; the
  controller enforces the busy-time and post-80h command limits, passes
  software 70h/71h status polls through, and decodes the status byte.
  Assumes an external pull-up on ready_busy_n and one device on CE.
  Limitation: page order is judged from the low six bits of the third
  address byte only, so a new block must start again at page 0.
*/
`timescale 1ns/1ps
// Behaviour
// - after 70h, each read strobe returns the status byte
// - host trusts pass/fail only after program/erase and when ready
// - on shared ready/busy lines, status reads find each device state
// - during power-on busy only FFh or 70h may be issued
// - host never issues an opcode outside the command set
// - while busy only 70h, 71h or FFh may be issued
// - after 80h only 85h, 10h, 11h, 15h or FFh may follow
// - pages within a block are programmed in ascending order; host only flags a repeated or lower page in order_err_r and still issues it
module nsrc_host (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output nsrc_pkg::nsrc_pins_type PINS,
  output logic [7:0] IO_OUT,
  output logic IO_OE,
  input wire logic [7:0] IO_IN,
  input wire logic READY_BUSY_N
);
  import nsrc_pkg::*;

  // two-stage synchronisers: the bus and the busy line change with no
  // relation to the core clock
  logic [7:0] io_s1_r, io_s2_r;
  logic rb_s1_r, rb_s2_r;
  always_ff @(posedge CORE_CLK) begin
    io_s1_r <= IO_IN;
    io_s2_r <= io_s1_r;
    rb_s1_r <= READY_BUSY_N;
    rb_s2_r <= rb_s1_r;
  end

  // decide whether an opcode is in the documented set
  function automatic logic known_op(input logic [7:0] op);
    known_op = op == CMD_READ_SETUP || op == CMD_READ_START ||
      op == CMD_CACHE_READ || op == CMD_SERIAL_IN ||
      op == CMD_COL_CHANGE || op == CMD_PROG_START ||
      op == CMD_MULTI_PROG || op == CMD_CACHE_PROG ||
      op == CMD_ERASE_SETUP || op == CMD_ERASE_START ||
      op == CMD_ID_READ || op == CMD_STATUS ||
      op == CMD_STATUS_MULTI || op == CMD_RESET;
  endfunction

  // program-type opcodes that write protect blocks
  function automatic logic prog_op(input logic [7:0] op);
    prog_op = op == CMD_SERIAL_IN || op == CMD_ERASE_SETUP ||
      op == CMD_PROG_START || op == CMD_CACHE_PROG ||
      op == CMD_MULTI_PROG || op == CMD_ERASE_START;
  endfunction

  logic [7:0] ctrl_r;
  logic [7:0] last_cmd_r, prev_cmd_r;
  logic [7:0] status_r;
  logic [7:0] rdata_r;
  logic after80_r, powerup_r, stat_mode_r, progop_r;
  logic rejected_r, status_valid_r;
  logic [5:0] last_page_r;
  logic order_err_r;
  logic cy_busy, cy_done, cy_we, cy_re, cy_cle, cy_ale, cy_oe;
  logic [7:0] cy_io, cy_rdata;
  logic start;
  nsrc_req_type req;
  logic dev_busy;
  logic wr_cmd, wr_addr, wr_data, rd_data;
  logic wr_ctrl, wr_stat, rd_cyc_r;
  nsrc_cyc_type req_kind;
  logic cmd_ok;
  logic [7:0] op;

  // busy comes only from the pulled-up pin; no pull-up reads as busy
  assign dev_busy = !rb_s2_r;
  assign op = WDATA;
  assign wr_cmd = WR && ADDR == REG_CMD;
  assign wr_addr = WR && ADDR == REG_ADDR;
  assign wr_data = WR && ADDR == REG_DATA;
  assign rd_data = WR && ADDR == REG_RDATA;
  // register writes that act on the controller itself
  assign wr_ctrl = WR && ADDR == REG_CTRL;
  assign wr_stat = WR && ADDR == REG_STATUS;

  // command gate: refuse illegal opcodes before they reach the pins; a
  // refused command never moves a strobe, so the device never sees it
  logic gate_known, gate_pwr, gate_busy, gate_p80, gate_wp;
  assign gate_known = known_op(op);
  // power-on window: only reset and status read
  assign gate_pwr = !powerup_r || op == CMD_RESET ||
    op == CMD_STATUS;
  // busy device: status polls and reset only, read in progress included
  assign gate_busy = !dev_busy || op == CMD_STATUS ||
    op == CMD_STATUS_MULTI || op == CMD_RESET;
  // serial input armed: only the program family, column change, reset
  assign gate_p80 = !after80_r || op == CMD_COL_CHANGE ||
    op == CMD_PROG_START || op == CMD_MULTI_PROG ||
    op == CMD_CACHE_PROG || op == CMD_RESET;
  // protected device: program and erase never leave the controller
  assign gate_wp = !prog_op(op) || ctrl_r[0];
  assign cmd_ok = gate_known && gate_pwr && gate_busy && gate_p80 &&
    gate_wp;

  // writes while the engine is busy are dropped; software polls first
  assign start = !cy_busy &&
    ((wr_cmd && cmd_ok) || wr_addr || wr_data || rd_data);
  // kind and data leave through one literal so req has one driver
  assign req_kind = wr_cmd ? NSRC_CYC_CMD : wr_addr ? NSRC_CYC_ADDR :
    wr_data ? NSRC_CYC_WDATA : NSRC_CYC_RDATA;
  assign req = '{kind: req_kind, data: WDATA};

  nsrc_cycle u_cycle (
    .clk(CORE_CLK),
    .rst(RESET),
    .start(start),
    .req(req),
    .io_sync(io_s2_r),
    .busy(cy_busy),
    .done(cy_done),
    .we_n(cy_we),
    .re_n(cy_re),
    .cle(cy_cle),
    .ale(cy_ale),
    .io_out(cy_io),
    .io_oe(cy_oe),
    .rdata(cy_rdata)
  );

  // pins: chip enable low from reset release onward; the whole struct
  // is built in one place so each member has exactly one driver
  assign PINS = '{
    ce_n: RESET,
    cle: cy_cle,
    ale: cy_ale,
    we_n: cy_we,
    read_strobe_n: cy_re,
    wp_n: ctrl_r[0]
  };
  assign IO_OUT = cy_io;
  assign IO_OE = cy_oe;

  // command history and sequencing state
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl_r <= CTRL_RESET;
      last_cmd_r <= CMD_RESET;
      prev_cmd_r <= CMD_RESET;
      after80_r <= 1'b0;
      powerup_r <= 1'b1;
      stat_mode_r <= 1'b0;
      progop_r <= 1'b0;
      rejected_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= WDATA;
      // power-on busy window closes at first ready seen
      if (!dev_busy) powerup_r <= 1'b0;
      if (wr_cmd && !cmd_ok) rejected_r <= 1'b1;
      else if (wr_stat) rejected_r <= 1'b0;
      if (start && wr_cmd) begin
        prev_cmd_r <= last_cmd_r;
        last_cmd_r <= op;
        // 80h arms; anything else other than 85h disarms
        if (op == CMD_SERIAL_IN) after80_r <= 1'b1;
        else if (op != CMD_COL_CHANGE) after80_r <= 1'b0;
        // status mode persists until 00h resumes the read column or FFh resets
        if (op == CMD_STATUS || op == CMD_STATUS_MULTI)
          stat_mode_r <= 1'b1;
        else if (op == CMD_READ_SETUP || op == CMD_RESET)
          stat_mode_r <= 1'b0;
        // pass/fail only means something after program or erase
        if (op == CMD_PROG_START || op == CMD_CACHE_PROG ||
            op == CMD_MULTI_PROG || op == CMD_ERASE_START)
          progop_r <= 1'b1;
        else if (op == CMD_READ_START || op == CMD_CACHE_READ ||
                 op == CMD_RESET)
          progop_r <= 1'b0;
      end
      // write protect drop ends any pending program set-up
      if (!ctrl_r[0]) after80_r <= 1'b0;
    end
  end

  // status capture: a read strobe in status mode yields the status byte
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      status_r <= 8'h00;
      status_valid_r <= 1'b0;
      rdata_r <= 8'h00;
      rd_cyc_r <= 1'b0;
    end else begin
      if (start) rd_cyc_r <= rd_data;
      // a write cycle leaves the engine's read byte stale, so only a
      // finished read cycle may update the captured bytes
      if (cy_done && rd_cyc_r) begin
        rdata_r <= cy_rdata;
        if (stat_mode_r) begin
          status_r <= cy_rdata;
          // pass/fail trusted only after program/erase when ready
          status_valid_r <= progop_r && cy_rdata[ST_BUF_READY];
        end
      end
    end
  end

  // decoded status view: bits masked when not valid
  logic pf0_ok, pf1_ok, cached, pairs_ok;
  logic [7:0] devstat;
  // the status command itself shifts history, so look one step back
  assign cached = last_cmd_r == CMD_CACHE_PROG ||
    prev_cmd_r == CMD_CACHE_PROG;
  assign pf0_ok = status_valid_r && status_r[ST_BUF_READY];
  assign pf1_ok = status_valid_r && cached &&
    status_r[ST_CACHE_READY];
  // ready bits must agree unless last command was 15h or 31h
  assign pairs_ok = status_r[ST_BUF_READY] == status_r[ST_CACHE_READY] ||
    prev_cmd_r == CMD_CACHE_PROG || prev_cmd_r == CMD_CACHE_READ;
  // fail bits read 0 unless the matching valid bit is set
  assign devstat = {
    status_r[ST_UNPROT],
    pairs_ok,
    pf1_ok && status_r[ST_SECONDARY],
    pf0_ok && status_r[ST_PRIMARY],
    pf1_ok,
    pf0_ok,
    status_r[ST_CACHE_READY],
    status_r[ST_BUF_READY]
  };

  // page order watch: address writes of third cycle carry page number
  // a flagged order error stays until software clears it in STATUS
  logic [2:0] acnt_r;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      acnt_r <= 3'h0;
      last_page_r <= 6'h00;
      order_err_r <= 1'b0;
    end else begin
      if (start && wr_cmd) acnt_r <= 3'h0;
      else if (start && wr_addr) acnt_r <= acnt_r + 3'h1;
      if (start && wr_addr && acnt_r == 3'h2 &&
          last_cmd_r == CMD_SERIAL_IN) begin
        if (WDATA[5:0] != 6'h00 && WDATA[5:0] <= last_page_r)
          order_err_r <= 1'b1;
        last_page_r <= WDATA[5:0];
      end
      if (wr_stat) order_err_r <= 1'b0;
    end
  end

  // register read port, data one cycle after the strobe; an if chain
  // keeps the map readable, and unmapped offsets read as zero
  logic [7:0] rd_mux;
  logic [7:0] stat_word;
  assign stat_word = {2'b00, order_err_r, rejected_r, after80_r,
    stat_mode_r, powerup_r, dev_busy || cy_busy};
  always_comb begin
    if (ADDR == REG_CTRL) begin
      rd_mux = ctrl_r;
    end else if (ADDR == REG_STATUS) begin
      rd_mux = stat_word;
    end else if (ADDR == REG_DEVSTAT) begin
      rd_mux = devstat;
    end else if (ADDR == REG_RDATA) begin
      rd_mux = rdata_r;
    end else if (ADDR == REG_CMD) begin
      rd_mux = last_cmd_r;
    end else begin
      rd_mux = 8'h00;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) RDATA <= 8'h00;
    else if (RD) RDATA <= rd_mux;
  end
endmodule

/* File: src/nsrc_pkg.sv */
/*
  Package for the NAND status/reset host controller: command opcodes,
  status byte layout, software register map and timing counts.
  Assumes a 250 MHz core clock and an asynchronous NAND device outside.
*/
package nsrc_pkg;
  // device opcodes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_START = 8'h30;
  localparam logic [7:0] CMD_CACHE_READ = 8'h31;
  localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
  localparam logic [7:0] CMD_COL_CHANGE = 8'h85;
  localparam logic [7:0] CMD_PROG_START = 8'h10;
  localparam logic [7:0] CMD_MULTI_PROG = 8'h11;
  localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_START = 8'hD0;
  localparam logic [7:0] CMD_ID_READ = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;
  localparam logic [7:0] CMD_RESET = 8'hFF;

  // status byte field positions
  localparam int ST_PRIMARY = 0;
  localparam int ST_SECONDARY = 1;
  localparam int ST_BUF_READY = 5;
  localparam int ST_CACHE_READY = 6;
  localparam int ST_UNPROT = 7;

  // software register offsets
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DEVSTAT = 4'h5;
  localparam logic [3:0] REG_RDATA = 4'h6;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // strobe timing: each phase of a device cycle
  localparam int CLK_MHZ = 250;
  localparam int PHASE_NS = 24;
  localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    NSRC_CYC_CMD,
    NSRC_CYC_ADDR,
    NSRC_CYC_WDATA,
    NSRC_CYC_RDATA
  } nsrc_cyc_type;

  typedef struct packed {
    nsrc_cyc_type kind;
    logic [7:0] data;
  } nsrc_req_type;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
  } nsrc_pins_type;
endpackage

/* File: src/nsrc_cycle.sv */
/*
  One NAND bus cycle engine: produces a write or read strobe pulse
  of two timed phases and captures read data at the rising edge.
  Latches req when start is taken, so the caller need not hold it while busy is high.
*/
`timescale 1ns/1ps
module nsrc_cycle #(
  parameter int PHASE = nsrc_pkg::PHASE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input nsrc_pkg::nsrc_req_type req,
  input wire logic [7:0] io_sync,
  output logic busy,
  output logic done,
  output logic we_n,
  output logic re_n,
  output logic cle,
  output logic ale,
  output logic [7:0] io_out,
  output logic io_oe,
  output logic [7:0] rdata
);
  import nsrc_pkg::*;
  typedef enum logic [1:0] {CY_IDLE, CY_LOW, CY_HIGH} nsrc_cy_type;
  nsrc_cy_type st_r;
  logic [7:0] cnt_r;
  nsrc_req_type req_r;
  logic is_rd;
  logic cnt_end;

  assign is_rd = (req_r.kind == NSRC_CYC_RDATA);
  assign cnt_end = (cnt_r == 8'(PHASE - 1));
  assign busy = (st_r != CY_IDLE);
  // strobes low only in the low phase; bus held through both phases
  assign we_n = !(st_r == CY_LOW && !is_rd);
  assign re_n = !(st_r == CY_LOW && is_rd);
  assign cle = busy && req_r.kind == NSRC_CYC_CMD;
  assign ale = busy && req_r.kind == NSRC_CYC_ADDR;
  assign io_out = req_r.data;
  assign io_oe = busy && !is_rd;

  // phase sequencer; a command is latched on the we_n rising edge
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      st_r <= CY_IDLE;
      cnt_r <= 8'h00;
      req_r <= '0;
      rdata <= 8'h00;
    end else begin
      case (st_r)
        CY_IDLE: begin
          cnt_r <= 8'h00;
          if (start) begin
            req_r <= req;
            st_r <= CY_LOW;
          end
        end
        CY_LOW: begin
          cnt_r <= cnt_end ? 8'h00 : cnt_r + 8'h01;
          // sample late in the low phase, io_sync lags two clocks
          if (cnt_end && is_rd) rdata <= io_sync;
          if (cnt_end) st_r <= CY_HIGH;
        end
        default: begin
          cnt_r <= cnt_end ? 8'h00 : cnt_r + 8'h01;
          if (cnt_end) begin
            st_r <= CY_IDLE;
            done <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule

/* File: test/nsrc_checker.sv */
/*
  Checker for the host pins and register read data of nsrc_host.
  Assumes one core clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module nsrc_checker (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input nsrc_pkg::nsrc_pins_type PINS,
  input wire logic [7:0] IO_OUT,
  input wire logic IO_OE
);
  import nsrc_pkg::*;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);
  // strobe phases are six clocks; $past guards skip the reset edge
  AST_WE_LOW: assert property ($fell(PINS.we_n) |->
    (!PINS.we_n)[*6] ##1 PINS.we_n) else $error("write strobe width");
  AST_RE_LOW: assert property ($fell(PINS.read_strobe_n) |->
    (!PINS.read_strobe_n)[*6] ##1 PINS.read_strobe_n)
    else $error("read strobe width");
  AST_WE_HIGH: assert property (!$past(RESET) && $rose(PINS.we_n) |->
    PINS.we_n[*6]) else $error("write strobe recovery");
  AST_CMD_DRIVE: assert property (PINS.cle && !PINS.we_n |->
    IO_OE && !PINS.ale && !PINS.ce_n) else $error("command cycle");
  AST_LATCH_HOLD: assert property (!$past(RESET) && $rose(PINS.we_n) |->
    $stable(PINS.cle) && $stable(IO_OUT) && $past(IO_OE))
    else $error("latch hold");
  AST_RD_TURN: assert property (!PINS.read_strobe_n |->
    !IO_OE && !PINS.cle && !PINS.ale) else $error("bus turn");
  AST_ONE_STROBE: assert property (PINS.we_n || PINS.read_strobe_n)
    else $error("both strobes low");
  AST_RDATA_HOLD: assert property ($changed(RDATA) && !$past(RESET) |->
    $past(RD)) else $error("read data moved");
  AST_WP_OUT: assert property ($fell(RESET) |-> !PINS.wp_n)
    else $error("protect after reset");
  // main traffic kinds
  cover property ($fell(PINS.we_n) && PINS.cle);
  cover property ($fell(PINS.we_n) && PINS.ale);
  cover property ($fell(PINS.read_strobe_n));
endmodule

bind nsrc_host nsrc_checker chk_i (.CORE_CLK(CORE_CLK), .RESET(RESET),
  .RD(RD), .RDATA(RDATA), .PINS(PINS), .IO_OUT(IO_OUT), .IO_OE(IO_OE));

/* File: test/nsrc_dev_model.sv */
/*
  Behavioural NAND device: command latch, status byte, busy timing.
  Assumes the host strobes change on core clock edges.
*/
`timescale 1ns/1ps
module nsrc_dev_model (
  input wire logic clk,
  input nsrc_pkg::nsrc_pins_type pins,
  input wire logic [7:0] io_in,
  output logic [7:0] io_dev,
  output logic rb_low
);
  import nsrc_pkg::*;
  int bsy_r = 300; // power-on busy
  int cbsy_r = 300;
  logic stat_r = 1'b0;
  logic p80_r = 1'b0;
  logic pg_r = 1'b0;
  logic pf_r = 1'b0;
  logic sf_r = 1'b0;
  logic we_q = 1'b1;
  logic re_q = 1'b1;
  logic [7:0] wd_r = 8'h00;
  logic [7:0] col_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  wire we_up = pins.we_n && !we_q && !pins.ce_n;
  // status byte; bits 2..4 fixed 0
  // the result bit appears only once the array is ready again
  wire [7:0] st = {pins.wp_n, cbsy_r == 0, bsy_r == 0, 3'b000, sf_r,
    pf_r && bsy_r == 0};
  // released bus shows the inverse of the last byte, not a held value
  assign io_dev = !pins.read_strobe_n && !pins.ce_n ?
    (stat_r ? st : 8'hA0 + col_r) : ~last_r;
  assign rb_low = cbsy_r != 0; // open drain pulls low only
  // sequencer; command assignments come last so they win
  always @(posedge clk) begin
    we_q <= pins.we_n;
    re_q <= pins.read_strobe_n;
    if (!pins.read_strobe_n) last_r <= io_dev;
    if (pins.read_strobe_n && !re_q && !stat_r) col_r <= col_r + 8'h01;
    if (!pins.wp_n && pg_r) begin
      bsy_r <= 0;
      cbsy_r <= 0;
      pg_r <= 1'b0;
    end else begin
      if (bsy_r > 0) bsy_r <= bsy_r - 1;
      if (cbsy_r > 0) cbsy_r <= cbsy_r - 1;
    end
    if (we_up && !pins.cle && !pins.ale) wd_r <= io_in;
    if (we_up && pins.cle) begin
      case (io_in)
        CMD_STATUS, CMD_STATUS_MULTI: stat_r <= 1'b1;
        CMD_READ_SETUP: stat_r <= 1'b0; // resumes at col_r
        CMD_COL_CHANGE: ;
        CMD_SERIAL_IN: p80_r <= 1'b1;
        CMD_READ_START: begin
          bsy_r <= 100;
          cbsy_r <= 100;
          col_r <= 8'h00;
        end
        CMD_RESET: begin
          bsy_r <= 5;
          cbsy_r <= 5;
          p80_r <= 1'b0;
          pg_r <= 1'b0;
          stat_r <= 1'b0;
        end
        CMD_PROG_START, CMD_CACHE_PROG: if (p80_r && pins.wp_n) begin
          pf_r <= wd_r[0];
          sf_r <= pf_r;
          bsy_r <= 200;
          cbsy_r <= io_in == CMD_CACHE_PROG ? 20 : 200;
          pg_r <= 1'b1;
          p80_r <= 1'b0;
        end
        default: begin
          p80_r <= 1'b0;
          stat_r <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* File: test/nsrc_host_test.sv */
/*
  Testbench for nsrc_host: register tasks drive command sequences.
  Assumes the device model and a pull-up on the ready/busy line.
*/
`timescale 1ns/1ps
module nsrc_host_test;
  import nsrc_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  nsrc_pins_type PINS;
  logic [7:0] IO_OUT;
  logic IO_OE;
  logic [7:0] dev_io;
  logic rb_low;
  logic [7:0] v;
  logic [7:0] d;
  int err_total = 0;
  int n_checks = 0;
  int k;
  // shared bus and pulled-up ready line
  wire [7:0] IO_IN = IO_OE ? IO_OUT : dev_io;
  wire READY_BUSY_N = rb_low ? 1'b0 : 1'b1;
  always #2 CORE_CLK = ~CORE_CLK;
  nsrc_host uut (.CORE_CLK(CORE_CLK), .RESET(RESET), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PINS(PINS),
    .IO_OUT(IO_OUT), .IO_OE(IO_OE), .IO_IN(IO_IN),
    .READY_BUSY_N(READY_BUSY_N));
  nsrc_dev_model dev (.clk(CORE_CLK), .pins(PINS), .io_in(IO_IN),
    .io_dev(dev_io), .rb_low(rb_low));
  task summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] ex);
    n_checks++;
    if (seen !== ex) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= x;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask
  // read data arrives in the cycle after the strobe and holds until the next read
  task rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1 x = RDATA;
  endtask
  // one device cycle; status bit 0 also shows device busy, so a poll
  // cannot tell the engine apart: wait out the fixed two-phase cycle
  task cyc(input logic [3:0] a, input logic [7:0] x);
    wr(a, x);
    repeat (2 * PHASE_CYC + 1) @(posedge CORE_CLK);
  endtask
  task dread(output logic [7:0] x);
    cyc(REG_RDATA, 8'h00);
    rd(REG_RDATA, x);
  endtask
  task st(input string nm, input logic [7:0] m, input logic [7:0] ex);
    rd(REG_STATUS, v);
    chk(nm, v & m, ex);
  endtask
  task wait_rdy;
    int j;
    for (j = 0; j < 500 && READY_BUSY_N !== 1'b1; j++) @(posedge CORE_CLK);
    repeat (4) @(posedge CORE_CLK);
  endtask
  task page(input logic [7:0] p);
    cyc(REG_ADDR, 8'h00);
    cyc(REG_ADDR, 8'h00);
    cyc(REG_ADDR, p);
  endtask
  initial begin
    #80000;
    err_total++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge CORE_CLK);
    RESET <= 1'b0;
    rd(REG_CTRL, v);
    chk("ctrl", v, CTRL_RESET);
    st("pwr", 8'h02, 8'h02);
    cyc(REG_CMD, CMD_ID_READ);
    st("pwr_rej", 8'h10, 8'h10);
    wr(REG_STATUS, 8'hFF);
    cyc(REG_CMD, CMD_STATUS);
    st("pwr_70", 8'h10, 8'h00);
    dread(d);
    chk("st_pwr", d, 8'h00);
    for (k = 0; k < 300 && v[1] !== 1'b0; k++) rd(REG_STATUS, v);
    chk("pwr_end", v & 8'h02, 8'h00);
    for (k = 0; k < 2; k++) begin
      dread(d);
      chk("st_rdy", d, 8'h60);
    end
    cyc(REG_CMD, 8'h5A);
    st("unknown", 8'h10, 8'h10);
    wr(REG_STATUS, 8'hFF);
    // erase while protected is refused
    cyc(REG_CMD, CMD_ERASE_SETUP);
    page(8'h00);
    cyc(REG_CMD, CMD_ERASE_START);
    st("wp_rej", 8'h10, 8'h10);
    wr(REG_STATUS, 8'hFF);
    cyc(REG_CMD, CMD_RESET);
    wait_rdy;
    // failing program, then busy-time command limits
    wr(REG_CTRL, 8'h01);
    cyc(REG_CMD, CMD_SERIAL_IN);
    page(8'h01);
    cyc(REG_DATA, 8'h01);
    cyc(REG_CMD, CMD_PROG_START);
    st("busy", 8'h01, 8'h01);
    cyc(REG_CMD, CMD_ID_READ);
    st("busy_rej", 8'h10, 8'h10);
    wr(REG_STATUS, 8'hFF);
    cyc(REG_CMD, CMD_STATUS);
    st("busy_70", 8'h10, 8'h00);
    dread(d);
    chk("st_busy", d, 8'h80);
    wait_rdy;
    dread(d);
    chk("st_fail", d, 8'hE1);
    rd(REG_DEVSTAT, d);
    chk("devstat", d, 8'hD7);
    // after 80h: illegal command, page order, release by reset
    cyc(REG_CMD, CMD_SERIAL_IN);
    st("after80", 8'h08, 8'h08);
    page(8'h01);
    st("order", 8'h20, 8'h20);
    cyc(REG_CMD, CMD_ID_READ);
    st("p80_rej", 8'h10, 8'h10);
    wr(REG_STATUS, 8'hFF);
    cyc(REG_CMD, CMD_COL_CHANGE);
    st("p80_85", 8'h18, 8'h08);
    cyc(REG_CMD, CMD_RESET);
    st("p80_ff", 8'h18, 8'h00);
    wait_rdy;
    // status poll inside a read, then output resumes
    cyc(REG_CMD, CMD_READ_SETUP);
    page(8'h02);
    cyc(REG_CMD, CMD_READ_START);
    cyc(REG_CMD, CMD_STATUS);
    st("rd_70", 8'h10, 8'h00);
    wait_rdy;
    dread(d);
    chk("rd_stmode", d & 8'hE0, 8'hE0);
    cyc(REG_CMD, CMD_READ_SETUP);
    for (k = 0; k < 2; k++) begin
      dread(d);
      chk("rd_data", d, 8'hA0 + k[7:0]);
    end
    summarize;
  end
endmodule
